// ==== include/ctt_pkg.sv ====
// Constants, opcodes, states and carriers for the trap, transfer and test execution core
package ctt_pkg;

    // Opcodes, prefixed stack forms carry the prefix byte in the upper half
    localparam logic [15:0] OP_SOFT_TRAP      = 16'h0083;
    localparam logic [15:0] OP_SLEEP          = 16'h008f;
    localparam logic [15:0] OP_ACC_TO_FLAGS   = 16'h0084;
    localparam logic [15:0] OP_FLAGS_TO_ACC   = 16'h0085;
    localparam logic [15:0] OP_ACC_TO_INDEX   = 16'h0097;
    localparam logic [15:0] OP_INDEX_TO_ACC   = 16'h009f;
    localparam logic [15:0] OP_STACK_TO_HX    = 16'h0095;
    localparam logic [15:0] OP_HX_TO_STACK    = 16'h0094;
    localparam logic [15:0] OP_TEST_PZ        = 16'h003d;
    localparam logic [15:0] OP_TEST_ACC       = 16'h004d;
    localparam logic [15:0] OP_TEST_INDEX     = 16'h005d;
    localparam logic [15:0] OP_TEST_IX1       = 16'h006d;
    localparam logic [15:0] OP_TEST_IX        = 16'h007d;
    localparam logic [15:0] OP_TEST_SP1       = 16'h9e6d;
    localparam logic [15:0] OP_LOAD_FULL      = 16'h00c6;
    localparam logic [15:0] OP_LOAD_IX1       = 16'h00e6;
    localparam logic [15:0] OP_LOAD_SP2       = 16'h9ed6;
    localparam logic [15:0] OP_CMPBR_PZ       = 16'h0031;
    localparam logic [15:0] OP_CMPBR_IXP      = 16'h0071;
    localparam logic [15:0] OP_MOVE_PZ_PZ     = 16'h004e;
    localparam logic [15:0] OP_MOVE_PZ_IXP    = 16'h005e;
    localparam logic [15:0] OP_MOVE_LIT_PZ    = 16'h006e;
    localparam logic [15:0] OP_MOVE_IXP_PZ    = 16'h007e;
    localparam logic [7:0]  PREFIX_BYTE       = 8'h9e;

    // Flags register layout, bits 6 and 5 always read as one
    localparam int          FLAG_V            = 7;
    localparam int          FLAG_I            = 3;
    localparam logic [7:0]  FLAGS_FIXED       = 8'h60;
    localparam logic [7:0]  FLAGS_RST         = 8'h68;

    // Reset values and trap vector location
    localparam logic [15:0] SP_RST            = 16'h00ff;
    localparam logic [15:0] PC_RST            = 16'h0000;
    localparam logic [15:0] VEC_HI_ADDR       = 16'hfffc;
    localparam logic [15:0] VEC_LO_ADDR       = 16'hfffd;
    localparam logic [2:0]  TRAP_LAST_PUSH    = 3'h4;
    localparam int          TRAP_CYCLES       = 9;

    typedef enum logic [2:0] {
        AM_PAGE_ZERO, AM_FULL, AM_IX, AM_IX1, AM_SP1, AM_SP2
    } ctt_mode_t;

    typedef enum {
        S_FETCH, S_OPND, S_EXEC, S_STORE, S_PUSH, S_VECH, S_VECL, S_SLEEP
    } ctt_state_t;

    typedef struct packed {
        logic [15:0] addr;
        logic        rd;
        logic        wr;
        logic [7:0]  wdata;
    } ctt_mem_req_t;

endpackage

// ==== core/ctt_ea_calc.sv ====
// Effective address former for the supported addressing modes
`timescale 1ns/10ps
module ctt_ea_calc
    import ctt_pkg::*;
(
    input  wire ctt_mode_t   mode_i,
    input  wire logic [15:0] opnd_i,
    input  wire logic [15:0] hx_i,
    input  wire logic [15:0] sp_i,
    output logic      [15:0] ea_o
);
    // Byte offsets are zero extended, word offsets are taken whole
    wire [15:0] byte_off = {8'h00, opnd_i[7:0]};

    // mode select; stack plus word takes two bytes whole, page zero is the default
    assign ea_o = (mode_i == AM_FULL) ? opnd_i :
                  (mode_i == AM_IX)   ? hx_i :
                  (mode_i == AM_IX1)  ? hx_i + byte_off :
                  (mode_i == AM_SP1)  ? sp_i + byte_off :
                  (mode_i == AM_SP2)  ? sp_i + opnd_i :
                  byte_off;
endmodule

// ==== core/ctt_core.sv ====
// Execution core for trap, sleep, zero/negative test, transfers and operand modes
`timescale 1ns/10ps
//
// Contract
// - Trap advances PC, pushes PC low, PC high, X, A, flags, masks, vectors; 9 cycles.
// - Sleep clears interrupt mask, then halts until an interrupt arrives.
// - Test sets N and Z from operand, clears V, keeps C, writes nothing.
// - Stack word-offset address is stack pointer plus 16-bit offset, high byte first.
// - Index byte-offset address is index pair plus one offset byte.
// - Full address comes as high byte then low byte.
// - Post-increment index uses index pair, then increments it.
// - Moves: literal to page zero, postinc to page zero, page zero to postinc.
// - Compare-branch carries page-zero address then signed offset added when taken.
module ctt_core
    import ctt_pkg::*;
(
    input  wire logic         ref_clk_i,
    input  wire logic         rst_n_i,
    input  wire logic [7:0]   mem_rdata_i,
    input  wire logic         irq_i,
    output ctt_mem_req_t      mem_req_o,
    output logic              sleep_o,
    output logic [15:0]       pc_o,
    output logic [15:0]       sp_o,
    output logic [15:0]       hx_o,
    output logic [7:0]        acc_o,
    output logic [7:0]        flags_o
);
    ctt_state_t   state_q, state_d;
    logic [15:0]  pc_q, pc_d, sp_q, sp_d, hx_q, hx_d, op_q, op_d, opnd_q, opnd_d;
    logic [7:0]   acc_q, acc_d, ccr_q, ccr_d, tmp_q, tmp_d;
    logic [2:0]   cnt_q, cnt_d;
    logic         pre_q, pre_d;
    ctt_mem_req_t req;
    logic [15:0]  ea;
    // Opcode seen by the decoder: the incoming byte during fetch, else the held one
    wire [15:0] op_w = (state_q == S_FETCH) ? {(pre_q ? PREFIX_BYTE : 8'h00), mem_rdata_i}
                                            : op_q;
    // Instruction class decode
    wire is_test_pz  = op_w == OP_TEST_PZ;
    wire is_test_ix1 = op_w == OP_TEST_IX1;
    wire is_test_ix  = op_w == OP_TEST_IX;
    wire is_test_sp1 = op_w == OP_TEST_SP1;
    wire is_test_mem = is_test_pz | is_test_ix1 | is_test_ix | is_test_sp1;
    wire is_test_reg = (op_w == OP_TEST_ACC) | (op_w == OP_TEST_INDEX);
    wire is_ld_full  = op_w == OP_LOAD_FULL;
    wire is_ld_ix1   = op_w == OP_LOAD_IX1;
    wire is_ld_sp2   = op_w == OP_LOAD_SP2;
    wire is_load     = is_ld_full | is_ld_ix1 | is_ld_sp2;
    wire is_cb_pz    = op_w == OP_CMPBR_PZ;
    wire is_cb_ixp   = op_w == OP_CMPBR_IXP;
    wire is_mv_dd    = op_w == OP_MOVE_PZ_PZ;
    wire is_mv_dixp  = op_w == OP_MOVE_PZ_IXP;
    wire is_mv_imd   = op_w == OP_MOVE_LIT_PZ;
    wire is_mv_ixpd  = op_w == OP_MOVE_IXP_PZ;
    wire is_move     = is_mv_dd | is_mv_dixp | is_mv_imd | is_mv_ixpd;
    wire reads_mem   = is_test_mem | is_load | is_cb_pz | is_cb_ixp | (is_move & !is_mv_imd);
    // Operand byte count per instruction
    wire two_bytes = is_ld_full | is_ld_sp2 | is_cb_pz | is_mv_dd | is_mv_imd;
    wire one_byte  = is_test_pz | is_test_ix1 | is_test_sp1 | is_ld_ix1 | is_cb_ixp
                   | is_mv_dixp | is_mv_ixpd;
    wire [2:0] dec_cnt = two_bytes ? 3'h2 : (one_byte ? 3'h1 : 3'h0);
    // Source side mode in execute, destination side in store
    wire ctt_mode_t src_mode = (is_test_ix1 | is_ld_ix1) ? AM_IX1 :
                               is_test_sp1               ? AM_SP1 :
                               is_ld_sp2                 ? AM_SP2 :
                               is_ld_full                ? AM_FULL :
                               (is_test_ix | is_cb_ixp | is_mv_ixpd) ? AM_IX :
                               AM_PAGE_ZERO;
    wire ctt_mode_t dst_mode = is_mv_dixp ? AM_IX : AM_PAGE_ZERO;
    wire ctt_mode_t cur_mode = (state_q == S_STORE) ? dst_mode : src_mode;
    // the first of two page-zero bytes is the source
    wire hi_is_pz = (state_q == S_EXEC) & (is_cb_pz | is_mv_dd);
    wire [15:0] ea_opnd = hi_is_pz ? {8'h00, opnd_q[15:8]} : opnd_q;
    ctt_ea_calc u_ea (
        .mode_i (cur_mode),
        .opnd_i (ea_opnd),
        .hx_i   (hx_q),
        .sp_i   (sp_q),
        .ea_o   (ea)
    );
    // flag source; a literal move takes its byte from the stream, not memory
    wire [7:0] flag_src = (op_w == OP_TEST_ACC)   ? acc_q :
                          (op_w == OP_TEST_INDEX) ? hx_q[7:0] :
                          is_mv_imd               ? opnd_q[15:8] : mem_rdata_i;
    wire [7:0] nz_ccr   = {1'b0, ccr_q[6:3], flag_src[7], flag_src == 8'h00, ccr_q[0]};
    wire [7:0] push_byte = (cnt_q == 3'h0) ? pc_q[7:0] :
                           (cnt_q == 3'h1) ? pc_q[15:8] :
                           (cnt_q == 3'h2) ? hx_q[7:0] :
                           (cnt_q == 3'h3) ? acc_q : ccr_q;
    wire [15:0] rel_ext  = {{8{opnd_q[7]}}, opnd_q[7:0]};
    wire        cb_taken = (is_cb_pz | is_cb_ixp) & (acc_q == mem_rdata_i);
    // post-increment points, source side in execute, destination side in store
    wire hx_inc = ((state_q == S_EXEC) & (is_cb_ixp | is_mv_ixpd))
                | ((state_q == S_STORE) & is_mv_dixp);
    // Sequencer; one memory access per cycle keeps the bus a plain strobe
    always_comb begin
        state_d = state_q;
        pc_d    = pc_q;
        sp_d    = sp_q;
        hx_d    = hx_inc ? hx_q + 16'h0001 : hx_q;
        acc_d   = acc_q;
        ccr_d   = ccr_q;
        op_d    = op_q;
        opnd_d  = opnd_q;
        tmp_d   = tmp_q;
        cnt_d   = cnt_q;
        pre_d   = pre_q;
        req     = '0;
        case (state_q)
            S_FETCH: begin
                req.addr = pc_q;
                req.rd   = 1'b1;
                pc_d     = pc_q + 16'h0001;
                if (!pre_q && mem_rdata_i == PREFIX_BYTE) begin
                    pre_d = 1'b1;
                end else begin
                    pre_d   = 1'b0;
                    op_d    = op_w;
                    opnd_d  = 16'h0000;
                    cnt_d   = dec_cnt;
                    state_d = (dec_cnt == 3'h0) ? S_EXEC : S_OPND;
                end
            end
            S_OPND: begin
                req.addr = pc_q;
                req.rd   = 1'b1;
                pc_d     = pc_q + 16'h0001;
                opnd_d   = {opnd_q[7:0], mem_rdata_i};
                cnt_d    = cnt_q - 3'h1;
                state_d  = (cnt_q == 3'h1) ? S_EXEC : S_OPND;
            end
            S_EXEC: begin
                state_d  = S_FETCH;
                req.addr = ea;
                req.rd   = reads_mem;
                if (op_q == OP_SOFT_TRAP) begin
                    cnt_d   = 3'h0;
                    state_d = S_PUSH;
                end
                if (op_q == OP_SLEEP) begin
                    ccr_d[FLAG_I] = 1'b0;
                    state_d       = S_SLEEP;
                end
                // full overwrite, fixed bits stay one
                if (op_q == OP_ACC_TO_FLAGS) begin
                    ccr_d = acc_q | FLAGS_FIXED;
                end
                if (op_q == OP_FLAGS_TO_ACC) begin
                    acc_d = ccr_q;
                end
                if (op_q == OP_ACC_TO_INDEX) begin
                    hx_d[7:0] = acc_q;
                end
                if (op_q == OP_INDEX_TO_ACC) begin
                    acc_d = hx_q[7:0];
                end
                if (op_q == OP_STACK_TO_HX) begin
                    hx_d = sp_q + 16'h0001;
                end
                if (op_q == OP_HX_TO_STACK) begin
                    sp_d = hx_q - 16'h0001;
                end
                if (is_test_mem | is_test_reg | is_load | is_move) begin
                    ccr_d = nz_ccr;
                end
                if (is_load) begin
                    acc_d = mem_rdata_i;
                end
                // source byte held for the store cycle
                if (is_move) begin
                    tmp_d   = is_mv_imd ? opnd_q[15:8] : mem_rdata_i;
                    state_d = S_STORE;
                end
                // taken branch adds the offset to the next PC
                if (cb_taken) begin
                    pc_d = pc_q + rel_ext;
                end
            end
            S_STORE: begin
                req.addr  = ea;
                req.wr    = 1'b1;
                req.wdata = tmp_q;
                state_d   = S_FETCH;
            end
            S_PUSH: begin
                // stack push, pointer falls after each byte
                req.addr  = sp_q;
                req.wr    = 1'b1;
                req.wdata = push_byte;
                sp_d      = sp_q - 16'h0001;
                cnt_d     = cnt_q + 3'h1;
                if (cnt_q == TRAP_LAST_PUSH) begin
                    ccr_d[FLAG_I] = 1'b1;
                    state_d       = S_VECH;
                end
            end
            S_VECH: begin
                req.addr    = VEC_HI_ADDR;
                req.rd      = 1'b1;
                pc_d[15:8]  = mem_rdata_i;
                state_d     = S_VECL;
            end
            S_VECL: begin
                req.addr    = VEC_LO_ADDR;
                req.rd      = 1'b1;
                pc_d[7:0]   = mem_rdata_i;
                state_d     = S_FETCH;
            end
            S_SLEEP: begin
                state_d = irq_i ? S_FETCH : S_SLEEP;
            end
            default: begin
                state_d = S_FETCH;
            end
        endcase
    end
    // State registers
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            state_q <= S_FETCH;
            pc_q    <= PC_RST;
            sp_q    <= SP_RST;
            hx_q    <= 16'h0000;
            acc_q   <= 8'h00;
            ccr_q   <= FLAGS_RST;
            op_q    <= 16'h0000;
            opnd_q  <= 16'h0000;
            tmp_q   <= 8'h00;
            cnt_q   <= 3'h0;
            pre_q   <= 1'b0;
        end else begin
            state_q <= state_d;
            pc_q    <= pc_d;
            sp_q    <= sp_d;
            hx_q    <= hx_d;
            acc_q   <= acc_d;
            ccr_q   <= ccr_d;
            op_q    <= op_d;
            opnd_q  <= opnd_d;
            tmp_q   <= tmp_d;
            cnt_q   <= cnt_d;
            pre_q   <= pre_d;
        end
    end
    // Architectural state is visible straight from the registers
    assign mem_req_o = req;
    assign sleep_o   = state_q == S_SLEEP;
    assign pc_o      = pc_q;
    assign sp_o      = sp_q;
    assign hx_o      = hx_q;
    assign acc_o     = acc_q;
    assign flags_o   = ccr_q;
    // Checks and scenario covers on the core clock, quiet while reset is held
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rst_n_i);
    wire ex = state_q == S_EXEC;
    trap_length_a: assert property ((state_q == S_FETCH && !pre_q && op_w == OP_SOFT_TRAP)
        |-> ##9 state_q == S_FETCH && ccr_q[FLAG_I]) else $error("trap length wrong");
    trap_push_a: assert property ((state_q == S_PUSH)
        |-> req.wr && req.addr == sp_q ##1 sp_q == $past(sp_q) - 16'h0001)
        else $error("trap push wrong");
    sleep_mask_a: assert property ((ex && op_q == OP_SLEEP)
        |=> sleep_o && !ccr_q[FLAG_I] && !mem_req_o.rd && !mem_req_o.wr)
        else $error("sleep entry wrong");
    test_flags_a: assert property ((ex && (is_test_mem || is_test_reg))
        |=> !ccr_q[FLAG_V] && ccr_q[0] == $past(ccr_q[0]) && acc_q == $past(acc_q))
        else $error("test flags wrong");
    word_offset_a: assert property ((ex && op_q == OP_LOAD_SP2)
        |-> mem_req_o.addr == sp_q + opnd_q) else $error("stack word address wrong");
    byte_offset_a: assert property ((ex && (is_test_ix1 || is_ld_ix1))
        |-> mem_req_o.addr == hx_q + {8'h00, opnd_q[7:0]})
        else $error("index byte address wrong");
    postinc_hx_a: assert property ((ex && (is_cb_ixp || is_mv_ixpd))
        |-> mem_req_o.addr == hx_q ##1 hx_q == $past(hx_q) + 16'h0001)
        else $error("post increment wrong");
    move_store_a: assert property ((ex && is_move)
        |=> mem_req_o.wr && mem_req_o.wdata == tmp_q ##1 state_q == S_FETCH)
        else $error("move store wrong");
    pair_xfer_a: assert property ((ex && op_q == OP_STACK_TO_HX)
        |=> hx_q == $past(sp_q) + 16'h0001 && ccr_q == $past(ccr_q))
        else $error("stack to pair wrong");
    flags_load_a: assert property ((ex && op_q == OP_ACC_TO_FLAGS)
        |=> ccr_q == ($past(acc_q) | FLAGS_FIXED)) else $error("flags load wrong");
    trap_seen_c: cover property (state_q == S_VECL);
    sleep_wake_c: cover property (sleep_o ##1 !sleep_o);
    branch_taken_c: cover property (ex && cb_taken);
    branch_skip_c: cover property (ex && is_cb_ixp && !cb_taken);
    move_dixp_c: cover property (state_q == S_STORE && is_mv_dixp);
endmodule

// ==== bench/ctt_mem_model.sv ====
// Byte-wide program and data memory that answers the core in the same cycle
`timescale 1ns/10ps
module ctt_mem_model
    import ctt_pkg::*;
(
    input  wire logic         ref_clk_i,
    input  wire ctt_mem_req_t req_i,
    output logic [7:0]        rdata_o
);
    logic [7:0] mem [0:65535];
    logic [7:0] last_q = 8'h00;

    // Cleared so that stray reads of unloaded places repeat from run to run
    initial begin
        for (int i = 0; i < 65536; i++) begin
            mem[i] = 8'h00;
        end
    end

    // Zero-wait read; while not selected the lines show the inverse of the last byte,
    // so a core that samples an idle bus cannot pick up a correct value by luck
    assign rdata_o = req_i.rd ? mem[req_i.addr] : ~last_q;

    // Stores land at the edge that sees the write strobe
    always @(posedge ref_clk_i) begin
        if (req_i.wr) begin
            mem[req_i.addr] <= req_i.wdata;
        end
        if (req_i.rd) begin
            last_q <= mem[req_i.addr];
        end
    end
endmodule

// ==== bench/cpu_trap_transfer_wait_ops_bench.sv ====
// Self-checking bench that runs a fixed program through the execution core
`timescale 1ns/10ps
module cpu_trap_transfer_wait_ops_bench;
    logic                  ref_clk;
    logic                  rst_n;
    logic                  irq;
    logic [7:0]            mem_rdata;
    ctt_pkg::ctt_mem_req_t mem_req;
    logic                  sleep;
    logic [15:0]           pc;
    logic [15:0]           sp;
    logic [15:0]           hx;
    logic [7:0]            acc;
    logic [7:0]            flags;
    int                    err_count;
    int                    total_checks;
    int                    cyc;
    int                    t_trap;
    // Program from 0000 up to the trap at 0020, then the code at the trap vector 0040
    logic [263:0]          prog_a = 264'hc61234_97_e605_84_3d86_85_9f_94_95_9ed60010_6e3c90_5e90_7e91_319305_c60080_0000_83;
    logic [111:0]          prog_b = 112'h4d_5d_6d01_7d_9e6d02_8f_4e8f95_7105;
    // Data bytes as address and value pairs
    logic [191:0]          dat = {24'h123480, 24'h008593, 24'h0086c0, 24'h008f5a,
                                  24'h0081a5, 24'h00935a, 24'h008280, 24'hfffd40};
    // Bytes the trap leaves at 007f down to 007b
    logic [39:0]           stk = 40'h21_00_82_5a_75;

    ctt_core i_dut (
        .ref_clk_i   (ref_clk),
        .rst_n_i     (rst_n),
        .mem_rdata_i (mem_rdata),
        .irq_i       (irq),
        .mem_req_o   (mem_req),
        .sleep_o     (sleep),
        .pc_o        (pc),
        .sp_o        (sp),
        .hx_o        (hx),
        .acc_o       (acc),
        .flags_o     (flags)
    );

    ctt_mem_model i_mem (
        .ref_clk_i (ref_clk),
        .req_i     (mem_req),
        .rdata_o   (mem_rdata)
    );

    // Clock and a cycle count for timing the trap
    initial ref_clk = 1'b0;
    always #10 ref_clk = ~ref_clk;
    always @(posedge ref_clk) cyc++;

    // Verdict and end of run, shared by the main sequence and the watchdog
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // Compare one value of up to 16 bits
    task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
        total_checks++;
        if (got !== exp) begin
            err_count++;
            $display("FAIL %0t %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic chk_mem(input logic [15:0] a, input logic [7:0] d);
        check({8'h00, i_mem.mem[a]}, {8'h00, d}, "memory byte");
    endtask

    // Wait, bounded, for a read at the given address; the core has no other progress signal
    task automatic run_to(input logic [15:0] a);
        int n;
        n = 0;
        do begin
            @(negedge ref_clk);
            n++;
        end while (!(mem_req.rd === 1'b1 && mem_req.addr === a) && n < 60);
        if (n >= 60) begin
            err_count++;
            $display("FAIL %0t no read from %h", $time, a);
        end
    endtask

    // Run to the next fetch, then check accumulator and flags left by the instruction
    task automatic step(input logic [15:0] a, input logic [7:0] ea, input logic [7:0] ef);
        run_to(a);
        check({8'h00, acc}, {8'h00, ea}, "accumulator");
        check({8'h00, flags}, {8'h00, ef}, "flags");
    endtask

    task automatic load(input logic [15:0] base, input logic [263:0] v, input int n);
        for (int i = 0; i < n; i++) begin
            i_mem.mem[base + 16'(i)] = v[8*(n-1-i) +: 8];
        end
    endtask

    // Watchdog: the program needs about 100 cycles, so 2000 means a hang
    initial begin
        #40000;
        err_count++;
        $display("FAIL %0t watchdog expired", $time);
        tally_and_finish();
    end

    // Main sequence
    initial begin
        rst_n = 1'b0;
        irq   = 1'b0;
        @(negedge ref_clk);
        load(16'h0000, prog_a, 33);
        load(16'h0040, {152'h0, prog_b}, 14);
        for (int i = 0; i < 8; i++) begin
            i_mem.mem[dat[24*i+8 +: 16]] = dat[24*i +: 8];
        end
        repeat (4) @(negedge ref_clk);
        check(pc, 16'h0000, "pc");
        check(sp, 16'h00ff, "sp");
        check(hx, 16'h0000, "hx");
        step(16'h0000, 8'h00, 8'h68);
        $display("test reset done");
        rst_n = 1'b1;
        step(16'h0003, 8'h80, 8'h6c);
        step(16'h0004, 8'h80, 8'h6c);
        check(hx, 16'h0080, "hx");
        step(16'h0006, 8'h93, 8'h6c);
        step(16'h0007, 8'h93, 8'hf3);
        step(16'h0009, 8'h93, 8'h75);
        step(16'h000a, 8'h75, 8'h75);
        step(16'h000b, 8'h80, 8'h75);
        step(16'h000c, 8'h80, 8'h75);
        check(sp, 16'h007f, "sp");
        step(16'h000d, 8'h80, 8'h75);
        check(hx, 16'h0080, "hx");
        step(16'h0011, 8'h5a, 8'h71);
        $display("test transfers done");
        step(16'h0014, 8'h5a, 8'h71);
        chk_mem(16'h0090, 8'h3c);
        step(16'h0016, 8'h5a, 8'h71);
        chk_mem(16'h0080, 8'h3c);
        check(hx, 16'h0081, "hx");
        step(16'h0018, 8'h5a, 8'h75);
        chk_mem(16'h0091, 8'ha5);
        check(hx, 16'h0082, "hx");
        $display("test moves done");
        run_to(16'h0020);
        t_trap = cyc;
        step(16'h0040, 8'h5a, 8'h7d);
        check(16'(cyc - t_trap), 16'd9, "trap cycles");
        check(sp, 16'h007a, "sp");
        for (int i = 0; i < 5; i++) begin
            chk_mem(16'h007f - 16'(i), stk[39-8*i -: 8]);
        end
        $display("test trap done");
        step(16'h0041, 8'h5a, 8'h79);
        step(16'h0042, 8'h5a, 8'h7d);
        step(16'h0044, 8'h5a, 8'h7b);
        step(16'h0045, 8'h5a, 8'h7d);
        step(16'h0048, 8'h5a, 8'h79);
        $display("test zero negative done");
        repeat (4) @(negedge ref_clk);
        check({15'h0, sleep}, 16'h0001, "sleep");
        check({14'h0, mem_req.rd, mem_req.wr}, 16'h0000, "bus idle");
        check({8'h00, flags}, 16'h0071, "flags");
        irq = 1'b1;
        run_to(16'h0049);
        irq = 1'b0;
        check({15'h0, sleep}, 16'h0000, "sleep");
        $display("test sleep done");
        step(16'h004c, 8'h5a, 8'h71);
        chk_mem(16'h0095, 8'h5a);
        step(16'h004e, 8'h5a, 8'h71);
        check(hx, 16'h0083, "hx");
        $display("test page zero move and branch done");
        tally_and_finish();
    end
endmodule
